// File: design/haom_matcher.sv
// haom_matcher: home logic request routing and address/opcode match events.
// assumes the register port, request and response strobes are synchronous to sys_clk.
// Notes on behaviour
// [RL1] a local miss to a locally homed line goes to home queue logic and link at once.
// [RL2] a remote agent supplying the line first sends home queue logic a completion.
// [RL3] a modified line returned by a remote agent for a read is written back to DRAM.
// [RL4] a remote snoop goes to both queues at once, and a cache hit signals completion.
// [RL5] a modified snoop hit for a load is written back and forwarded onto the link.
// [RL6] an address match event fires when the message address equals bits 39:3.
// [RL7] an opcode match event fires when the message opcode equals bits 47:40.
// [RL8] bits 63:61 select address, opcode, OR or AND matching, or nothing.
// [RL9] reset clears all fields, and zero mode disables event generation.
// [RL10] events go out under event select 35 with unit mask 01 io hub, 02 remote, 04 local.
// [RL11] opcode-only mode with opcode 19 counts forward-invalidate responses.
// [RL12] opcode-only mode with opcode 1a counts forward-shared responses.
// [RL13] opcode-only mode with opcode 1d counts implicit-writeback responses.
// [RL14] each matching message gives one pulse, registered one cycle after the compare.
`timescale 1ns/10ps
module haom_matcher (
  input wire logic sys_clk, // 20 MHz clock
  input wire logic rst_b, // async reset, active low
  input wire logic reg_wr, // register write strobe
  input wire logic reg_rd, // register read strobe
  input wire logic [11:0] reg_idx, // register index
  input wire logic [63:0] reg_wdata, // write data
  output logic [63:0] reg_rdata, // read data, registered
  input wire logic miss_valid, // cache miss to local home from local requester
  input wire logic [36:0] miss_addr, // miss line address
  output logic home_req, // request to home queue logic
  output logic link_req, // request onto the link
  output logic [36:0] req_addr, // address of forwarded request
  input wire logic remote_data, // remote agent supplied the line
  input wire logic remote_modified, // supplied line was modified
  output logic home_cmpl, // completion to home queue logic
  output logic dram_wb, // writeback to dram
  input wire logic snp_valid, // remote snoop for local line
  input wire logic snp_load, // snoop is for a load
  input wire logic snp_hit, // cache holds the line
  input wire logic snp_modified, // line modified in cache or cores
  output logic grq_snp, // snoop to global request queue
  output logic home_snp, // snoop to home queue logic
  output logic link_fwd, // forward line onto link
  input wire haom_pkg::haom_msg_s msg_in, // message seen by home logic
  output logic match_evt, // match pulse to counters
  output logic [7:0] match_evsel, // event select
  output logic [7:0] match_umask // unit mask of source
);
  logic [63:0] ctrl_q;
  logic [63:0] rdata_q;
  haom_pkg::haom_state_e st_q, st_d;
  logic [36:0] addr_q;
  logic evt_q;
  logic [7:0] umask_q;
  logic home_req_q;
  logic link_req_q;
  logic cmpl_q;
  logic wb_q;
  logic grq_q;
  logic hsnp_q;
  logic fwd_q;
  logic hit;

  // register port decode
  wire logic sel_ctrl = reg_idx == haom_pkg::REG_MATCH_CTRL_IDX;
  wire logic ctrl_wr = reg_wr & sel_ctrl;
  // unmapped indices read zero
  wire logic [63:0] rd_mux = sel_ctrl ? ctrl_q : 64'h0;
  wire logic [7:0] src_umask =
    (msg_in.src == haom_pkg::HAOM_SRC_LOCAL) ? haom_pkg::UMASK_LOCAL :
    (msg_in.src == haom_pkg::HAOM_SRC_REMOTE) ? haom_pkg::UMASK_REMOTE :
    haom_pkg::UMASK_IO_HUB; // [RL10]
  // request flow decode
  wire logic miss_take = miss_valid & (st_q == haom_pkg::HAOM_ST_IDLE); // [RL1]
  // a supply with no miss pending is ignored, so a stray one cannot complete
  wire logic remote_first = (st_q == haom_pkg::HAOM_ST_WAIT) & remote_data; // [RL2]
  wire logic snp_mod_load = snp_valid & snp_modified & snp_load; // [RL5]
  wire logic snp_cmpl = snp_valid & snp_hit; // [RL4]
  // next values of the registers
  wire logic cmpl_d = remote_first | snp_cmpl; // [RL2] [RL4]
  wire logic wb_d = (remote_first & remote_modified) | snp_mod_load; // [RL3] [RL5]
  wire logic [36:0] addr_d = miss_take ? miss_addr : addr_q;
  wire logic [63:0] ctrl_d = ctrl_wr ? reg_wdata : ctrl_q;
  wire logic [63:0] rdata_d = reg_rd ? rd_mux : rdata_q;
  wire logic [7:0] umask_d = hit ? src_umask : 8'h00; // [RL10]

  // the opcodes of [RL11] [RL12] [RL13] are matched by the generic opcode compare
  haom_compare i_haom_compare (
    .ctrl(ctrl_q),
    .msg(msg_in),
    .hit(hit)
  );

  always_comb begin
    st_d = st_q;
    case (st_q)
      haom_pkg::HAOM_ST_IDLE: begin
        if (miss_valid) begin
          st_d = haom_pkg::HAOM_ST_WAIT;
        end
      end
      haom_pkg::HAOM_ST_WAIT: begin
        if (remote_data) begin
          st_d = remote_modified ? haom_pkg::HAOM_ST_WRITEBK : haom_pkg::HAOM_ST_IDLE;
        end
      end
      haom_pkg::HAOM_ST_WRITEBK: st_d = haom_pkg::HAOM_ST_IDLE;
      default: st_d = haom_pkg::HAOM_ST_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      ctrl_q <= haom_pkg::MATCH_CTRL_RESET; // [RL9]
    end else begin
      ctrl_q <= ctrl_d;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      rdata_q <= 64'h0;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      st_q <= haom_pkg::HAOM_ST_IDLE;
    end else begin
      st_q <= st_d;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      addr_q <= 37'h0;
    end else begin
      addr_q <= addr_d;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      home_req_q <= 1'b0;
    end else begin
      home_req_q <= miss_take; // [RL1]
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      link_req_q <= 1'b0;
    end else begin
      link_req_q <= miss_take; // [RL1]
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      cmpl_q <= 1'b0;
    end else begin
      cmpl_q <= cmpl_d; // [RL2] [RL4]
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      wb_q <= 1'b0;
    end else begin
      wb_q <= wb_d; // [RL3] [RL5]
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      grq_q <= 1'b0;
    end else begin
      grq_q <= snp_valid; // [RL4]
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      hsnp_q <= 1'b0;
    end else begin
      hsnp_q <= snp_valid; // [RL4]
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      fwd_q <= 1'b0;
    end else begin
      fwd_q <= snp_mod_load; // [RL5]
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      evt_q <= 1'b0;
    end else begin
      evt_q <= hit; // [RL14]
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      umask_q <= 8'h00;
    end else begin
      umask_q <= umask_d; // [RL10]
    end
  end

  assign reg_rdata = rdata_q;
  assign home_req = home_req_q;
  assign link_req = link_req_q;
  assign req_addr = addr_q;
  assign home_cmpl = cmpl_q;
  assign dram_wb = wb_q;
  assign grq_snp = grq_q;
  assign home_snp = hsnp_q;
  assign link_fwd = fwd_q;
  assign match_evt = evt_q;
  assign match_evsel = haom_pkg::PERF_EVENT_SEL; // [RL10]
  assign match_umask = umask_q;
endmodule

// File: include/haom_pkg.sv
// haom_pkg: constants and carrier types for the home agent opcode matcher.
// assumes one 20 MHz clock domain; register index 0x396 selects the match control word.
package haom_pkg;
  localparam logic [11:0] REG_MATCH_CTRL_IDX = 12'h396;
  localparam logic [63:0] MATCH_CTRL_RESET = 64'h0;
  localparam int ADDR_LSB = 3;
  localparam int ADDR_MSB = 39;
  localparam int OPC_LSB = 40;
  localparam int OPC_MSB = 47;
  localparam int MODE_LSB = 61;
  localparam int MODE_MSB = 63;
  localparam int ADDR_W = ADDR_MSB - ADDR_LSB + 1;
  localparam int OPC_W = OPC_MSB - OPC_LSB + 1;
  localparam logic [7:0] PERF_EVENT_SEL = 8'h35;
  localparam logic [7:0] UMASK_IO_HUB = 8'h01;
  localparam logic [7:0] UMASK_REMOTE = 8'h02;
  localparam logic [7:0] UMASK_LOCAL = 8'h04;
  localparam logic [7:0] OPC_FWD_INVALIDATE = 8'h19;
  localparam logic [7:0] OPC_FWD_SHARED = 8'h1a;
  localparam logic [7:0] OPC_IMPLICIT_WB = 8'h1d;

  typedef enum logic [1:0] {
    HAOM_SRC_IO_HUB = 2'b00,
    HAOM_SRC_LOCAL  = 2'b01,
    HAOM_SRC_REMOTE = 2'b10
  } haom_src_e;

  // one request or response seen by the home logic
  typedef struct packed {
    logic valid;
    logic [ADDR_W-1:0] addr;
    logic [OPC_W-1:0] opcode;
    haom_src_e src;
  } haom_msg_s;

  typedef enum logic [1:0] {
    HAOM_ST_IDLE    = 2'b00,
    HAOM_ST_WAIT    = 2'b01,
    HAOM_ST_WRITEBK = 2'b10
  } haom_state_e;
endpackage

// File: design/haom_compare.sv
// haom_compare: one compare stage, address and opcode against the control word.
// assumes the control word is stable for the cycle of the compare.
`timescale 1ns/10ps
module haom_compare (
  input wire logic [63:0] ctrl, // match control word
  input wire haom_pkg::haom_msg_s msg, // incoming message
  output logic hit // selected match condition
);
  wire logic [2:0] mode = ctrl[haom_pkg::MODE_MSB:haom_pkg::MODE_LSB];
  wire logic addr_eq = msg.addr == ctrl[haom_pkg::ADDR_MSB:haom_pkg::ADDR_LSB]; // [RL6]
  wire logic opc_eq = msg.opcode == ctrl[haom_pkg::OPC_MSB:haom_pkg::OPC_LSB]; // [RL7]
  logic sel;
  always_comb begin
    case (mode) // [RL8]
      3'b100, 3'b101: sel = addr_eq;
      3'b010, 3'b011: sel = opc_eq;
      3'b110, 3'b111: sel = addr_eq | opc_eq;
      3'b001: sel = addr_eq & opc_eq;
      default: sel = 1'b0; // [RL9]
    endcase
  end
  // gating by mode != 3'b000 keeps the compare quiet when mode is all zero
  assign hit = msg.valid & (mode != 3'b000) & sel; // [RL9]
endmodule

// File: sim/haom_matcher_properties.sv
// checker: port timing of haom_matcher.
// assumes bind into the matcher; control word shadowed from writes.
`timescale 1ns/10ps
module haom_matcher_properties (
  input wire logic sys_clk, // clock
  input wire logic rst_b, // reset, active low
  input wire logic reg_wr, // write strobe
  input wire logic reg_rd, // read strobe
  input wire logic [11:0] reg_idx, // index
  input wire logic [63:0] reg_wdata, // write data
  input wire logic [63:0] reg_rdata, // read data
  input wire logic miss_valid, // miss strobe
  input wire logic remote_data, // remote supply
  input wire logic remote_modified, // supplied line modified
  input wire logic [36:0] miss_addr, // miss address
  input wire logic [36:0] req_addr, // forwarded address
  input wire logic home_req, // home request
  input wire logic link_req, // link request
  input wire logic home_cmpl, // completion
  input wire logic dram_wb, // writeback
  input wire logic snp_valid, // snoop strobe
  input wire logic snp_load, // snoop for a load
  input wire logic snp_hit, // cache hit
  input wire logic snp_modified, // line modified
  input wire logic grq_snp, // snoop to global queue
  input wire logic home_snp, // snoop to home queue
  input wire logic link_fwd, // forward to link
  input wire logic match_evt, // match pulse
  input wire haom_pkg::haom_msg_s msg_in, // message
  input wire logic [7:0] match_evsel, // event select
  input wire logic [7:0] match_umask // unit mask
);
  logic [63:0] c_q;
  logic am;
  logic om;
  logic hit;
  logic fwd;
  logic [7:0] um;
  logic [7:0] um_exp;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_b);
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      c_q <= 64'h0;
    end else if (reg_wr && reg_idx == 12'h396) begin
      c_q <= reg_wdata;
    end
  end
  assign am = msg_in.addr == c_q[39:3];
  assign om = msg_in.opcode == c_q[47:40];
  // 001 is the only and-mode, so 000 never hits
  assign hit = msg_in.valid && (c_q[63] && am || c_q[62] && om
    || c_q[63:61] == 3'h1 && am && om);
  assign um = msg_in.src[0] ? 8'h04 : msg_in.src[1] ? 8'h02 : 8'h01;
  assign um_exp = hit ? um : 8'h00;
  assign fwd = snp_valid && snp_load && snp_modified;
  property p_match;
    1'b1 |=> match_evt == $past(hit);
  endproperty
  a_match: assert property (p_match) else $error("bad match");
  property p_umask;
    1'b1 |=> match_evsel == 8'h35 && match_umask == $past(um_exp);
  endproperty
  a_umask: assert property (p_umask) else $error("bad mask");
  property p_miss;
    home_req |-> link_req && $past(miss_valid) && req_addr == $past(miss_addr);
  endproperty
  a_miss: assert property (p_miss) else $error("bad miss");
  property p_snp;
    snp_valid |=> grq_snp && home_snp && (home_cmpl || !$past(snp_hit));
  endproperty
  a_snp: assert property (p_snp) else $error("bad snoop");
  property p_fwd;
    fwd |=> link_fwd && dram_wb;
  endproperty
  a_fwd: assert property (p_fwd) else $error("bad fwd");
  property p_wb;
    dram_wb |-> $past(fwd) || $past(remote_data) && $past(remote_modified);
  endproperty
  a_wb: assert property (p_wb) else $error("bad wb");
  property p_cmpl;
    home_cmpl |-> $past(remote_data) || $past(snp_valid) && $past(snp_hit);
  endproperty
  a_cmpl: assert property (p_cmpl) else $error("bad cmpl");
  property p_rd;
    reg_rd |=> reg_rdata == ($past(reg_idx) == 12'h396 ? $past(c_q) : 64'h0);
  endproperty
  a_rd: assert property (p_rd) else $error("bad read");
endmodule
bind haom_matcher haom_matcher_properties i_haom_matcher_properties (.*);

// File: sim/haom_counter.sv
// haom_counter: performance counter model on the match pulse.
// assumes pulses synchronous to sys_clk.
`timescale 1ns/10ps
module haom_counter (
  input wire logic sys_clk, // clock
  input wire logic rst_b, // reset
  input wire logic evt, // pulse
  input wire logic [7:0] evsel, // select
  output logic [15:0] count // total
);
  always_ff @(posedge sys_clk or negedge rst_b)
    if (!rst_b) count <= 16'h0;
    else if (evt && evsel == 8'h35) count <= count + 16'h1;
endmodule

// File: sim/haom_matcher_tb.sv
// haom_matcher_tb: register, match, miss and snoop sequences.
// assumes the counter model on the match pulse.
`timescale 1ns/10ps
`define CHK(a, b) \
  begin \
    total_checks++; \
    if ((a) !== (b)) begin \
      errors++; \
      $display("Error t=%0t got %h exp %h", $time, (a), (b)); \
    end \
  end
module haom_matcher_tb;
  logic sys_clk = 0, rst_b = 0, reg_wr = 0, reg_rd = 0, miss_valid = 0, remote_data = 0;
  logic remote_modified = 0, snp_valid = 0, snp_load = 0, snp_hit = 0, snp_modified = 0;
  logic [11:0] reg_idx = 12'h0;
  logic [63:0] reg_wdata = 64'h0, reg_rdata;
  logic [36:0] miss_addr = 37'h1234, req_addr;
  haom_pkg::haom_msg_s msg_in = '0;
  logic home_req, link_req, home_cmpl, dram_wb, grq_snp, home_snp, link_fwd, match_evt;
  logic [7:0] match_evsel, match_umask, um [3] = '{8'h01, 8'h04, 8'h02}, op [3];
  logic [15:0] count, n_evt = 16'h0;
  logic [4:0] sx;
  int errors = 0, total_checks = 0;
  haom_matcher i_haom_matcher (.*);
  haom_counter i_haom_counter (.sys_clk, .rst_b, .evt(match_evt), .evsel(match_evsel), .count);
  initial forever #25 sys_clk = ~sys_clk;
  task automatic cyc();
    @(negedge sys_clk);
  endtask
  task automatic wr(input logic [11:0] i, input logic [63:0] d);
    cyc();
    reg_wr = 1'b1;
    reg_idx = i;
    reg_wdata = d;
    cyc();
    reg_wr = 1'b0;
  endtask
  task automatic rd(input logic [11:0] i, input logic [63:0] e);
    cyc();
    reg_rd = 1'b1;
    reg_idx = i;
    cyc();
    reg_rd = 1'b0;
    `CHK(reg_rdata, e)
  endtask
  task automatic snd(input logic [7:0] o, input logic [36:0] a, input int s, input logic e);
    cyc();
    msg_in = '{1'b1, a, o, haom_pkg::haom_src_e'(s[1:0])};
    cyc();
    msg_in.valid = 1'b0;
    n_evt += {15'h0, e};
    `CHK({match_evt, match_umask}, {e, e ? um[s] : 8'h00})
  endtask
  task automatic stop_test();
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  initial begin
    repeat (3000) @(posedge sys_clk);
    errors++;
    stop_test();
  end
  initial begin
    op = '{8'h19, 8'h1a, 8'h1d};
    repeat (4) cyc();
    rst_b = 1'b1;
    rd(12'h396, 64'h0);
    wr(12'h395, '1);
    rd(12'h395, 64'h0);
    $display("test reg done");
    for (int m = 0; m < 8; m++) begin
      wr(12'h396, {m[2:0], 13'h0, 8'h1d, 37'h0abcd, 3'h0});
      snd(8'h1c, 37'h0abcd, m % 3, m[2]);
      snd(8'h1d, 37'h0abce, m % 3, m[1]);
      snd(8'h1d, 37'h0abcd, m % 3, m != 0);
    end
    for (int j = 0; j < 9; j++) begin
      wr(12'h396, {16'h4000, op[j % 3], 40'h0});
      snd(op[j % 3], 37'h0, j / 3, 1'b1);
      snd(op[(j + 1) % 3], 37'h0, j / 3, 1'b0);
    end
    `CHK(count, n_evt)
    rd(12'h395, 64'h0);
    rd(12'h396, 64'h40001d0000000000);
    $display("test match done");
    for (int w = 0; w < 2; w++) begin
      cyc();
      miss_valid = 1'b1;
      cyc();
      miss_valid = 1'b0;
      `CHK({home_req, link_req, req_addr}, {2'b11, 37'h1234})
      repeat (w * 3) cyc();
      cyc();
      remote_data = 1'b1;
      remote_modified = w[0];
      cyc();
      remote_data = 1'b0;
      `CHK({home_cmpl, dram_wb}, {1'b1, w[0]})
    end
    for (int k = 0; k < 8; k++) begin
      cyc();
      {snp_valid, snp_load, snp_hit, snp_modified} = {1'b1, k[2:0]};
      cyc();
      snp_valid = 1'b0;
      sx = {2'b11, k[1], {2{k[2] & k[0]}}};
      `CHK({grq_snp, home_snp, home_cmpl, dram_wb, link_fwd}, sx)
    end
    $display("test flow done");
    cyc();
    rst_b = 1'b0;
    cyc();
    `CHK({reg_rdata, req_addr}, {64'h0, 37'h0})
    `CHK({match_umask, match_evsel}, {8'h00, 8'h35})
    rst_b = 1'b1;
    rd(12'h396, 64'h0);
    $display("test reset done");
    stop_test();
  end
endmodule
